/* File: include/ppslc_pkg.sv */
package ppslc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock rate and deep power-down timing.
    localparam longint unsigned CLK_HZ = 64'h0000_0000_0773_5940;
    localparam longint unsigned DPD_TIME_S = 64'h0000_0000_0000_0020;
    localparam logic [31:0] DPD_CYCLES = 32'(DPD_TIME_S * CLK_HZ);

    ////////////////////////////////////////////////////////////////////////
    // Management register addresses.
    localparam logic [4:0] REG_CONTROL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_ID_HIGH = 5'h02;
    localparam logic [4:0] REG_ID_LOW = 5'h03;
    localparam logic [4:0] REG_ADVERT = 5'h04;
    localparam logic [4:0] REG_PARTNER = 5'h05;
    localparam logic [4:0] REG_EXPANSION = 5'h06;
    localparam logic [4:0] REG_NP_TX = 5'h07;
    localparam logic [4:0] REG_NP_PARTNER = 5'h08;
    localparam logic [4:0] REG_RSVD_FIRST = 5'h09;
    localparam logic [4:0] REG_RSVD_LAST = 5'h0F;
    localparam logic [4:0] REG_LED_CFG = 5'h14;
    localparam logic [4:0] REG_PD_SEL = 5'h18;

    ////////////////////////////////////////////////////////////////////////
    // Control register bit positions, write mask and reset value.
    localparam int CTL_RESET = 15;
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_SPEED = 13;
    localparam int CTL_ANEN = 12;
    localparam int CTL_LOWPWR = 11;
    localparam int CTL_ISOLATE = 10;
    localparam int CTL_ANRST = 9;
    localparam int CTL_DUPLEX = 8;
    localparam logic [15:0] CTL_RW_MASK = 16'h7D80;
    localparam logic [15:0] CTL_RESET_VAL = 16'h3100;

    ////////////////////////////////////////////////////////////////////////
    // Status and identifier values; identifier codes are arbitrary.
    localparam int STS_LINK = 2;
    localparam logic [15:0] STS_FIXED = 16'h7809;
    localparam logic [15:0] ID_HIGH_VAL = 16'h0A5A;
    localparam logic [15:0] ID_LOW_VAL = 16'hC3C0;
    localparam logic [15:0] ADVERT_RESET = 16'h0000;
    localparam logic [15:0] NP_TX_RESET = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Indicator configuration and section select fields.
    localparam int LED_SEL_W = 3;
    localparam int LED0_SEL_LSB = 0;
    localparam int LED1_SEL_LSB = 4;
    localparam logic [15:0] LED_CFG_RESET = 16'h0010;
    localparam int PD_SEL_LSB = 4;
    localparam int PD_SEL_W = 5;
    localparam logic [15:0] PD_SEL_RESET = 16'h01F0;

    ////////////////////////////////////////////////////////////////////////
    // Management frame layout.
    localparam logic [5:0] PRE_ONES = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0B;
    localparam logic [5:0] DATA_LAST = 6'h0F;
    localparam int HDR_OP_LSB = 10;
    localparam int HDR_PHY_LSB = 5;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [2:0] {LED_LINK, LED_ACT, LED_TX, LED_RX, LED_SPEED, LED_DUPLEX} ppslc_led_src_e;

    typedef struct packed {
        logic valid;
        logic [4:0] addr;
        logic [15:0] data;
    } ppslc_req_s;

    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic autoneg_en;
        logic low_power;
        logic isolate;
        logic full_duplex;
        logic an_restart;
        logic soft_reset;
    } ppslc_ctrl_s;

endpackage

/* File: core/ppslc_mdio_slave.sv */
`timescale 1ns/1ps
module ppslc_mdio_slave (
    // Clock and reset
    input logic clk_i,
    input logic reset_n_i,
    // Management pins
    input logic mdc_i,
    input logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    // Register side
    input logic [4:0] phy_addr_i,
    input logic [15:0] rd_data_i,
    output ppslc_pkg::ppslc_req_s req_o
);

    typedef enum logic [2:0] {ST_PRE, ST_START, ST_HDR, ST_TA, ST_DATA} ppslc_mdio_st_e;

    ppslc_mdio_st_e state_reg;
    logic [2:0] mdc_sync_reg;
    logic [1:0] mdio_sync_reg;
    logic [5:0] cnt_reg;
    logic [15:0] shift_reg;
    logic rd_reg;
    logic bit_edge;
    logic bit_val;
    logic [11:0] hdr;
    logic [1:0] hdr_op;

    ////////////////////////////////////////////////////////////////////////
    // Both pins pass two flip-flops; the third stage only finds the edge.
    always_ff @(posedge clk_i) begin
        mdc_sync_reg <= {mdc_sync_reg[1:0], mdc_i};
        mdio_sync_reg <= {mdio_sync_reg[0], mdio_i};
    end

    // A bit is taken on each rising edge of the management clock.
    assign bit_edge = mdc_sync_reg[1] & ~mdc_sync_reg[2];
    assign bit_val = mdio_sync_reg[1];
    assign hdr = {shift_reg[10:0], bit_val};
    assign hdr_op = hdr[ppslc_pkg::HDR_OP_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////
    // Frame engine: preamble, start, header, turnaround and data.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_PRE;
            cnt_reg <= 6'h00;
            shift_reg <= 16'h0000;
            rd_reg <= 1'h0;
            mdio_o <= 1'h0;
            mdio_oe_o <= 1'h0;
            req_o <= '0;
        end else begin
            req_o.valid <= 1'h0;
            if (bit_edge) begin
                unique case (state_reg)
                    ST_PRE: begin
                        if (bit_val) begin
                            if (cnt_reg != ppslc_pkg::PRE_ONES) begin
                                cnt_reg <= cnt_reg + 6'h01;
                            end
                        end else if (cnt_reg == ppslc_pkg::PRE_ONES) begin
                            state_reg <= ST_START;
                        end else begin
                            cnt_reg <= 6'h00;
                        end
                    end
                    ST_START: begin
                        cnt_reg <= 6'h00;
                        state_reg <= bit_val ? ST_HDR : ST_PRE;
                    end
                    ST_HDR: begin
                        shift_reg <= {shift_reg[14:0], bit_val};
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg == ppslc_pkg::HDR_LAST) begin
                            cnt_reg <= 6'h00;
                            // Frames for another address or with a bad opcode are dropped.
                            if (hdr[ppslc_pkg::HDR_PHY_LSB +: 5] == phy_addr_i &&
                                (hdr_op == ppslc_pkg::OP_READ || hdr_op == ppslc_pkg::OP_WRITE)) begin
                                state_reg <= ST_TA;
                                rd_reg <= (hdr_op == ppslc_pkg::OP_READ);
                                req_o.addr <= hdr[4:0];
                            end else begin
                                state_reg <= ST_PRE;
                            end
                        end
                    end
                    ST_TA: begin
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg == 6'h00) begin
                            mdio_oe_o <= rd_reg;
                            mdio_o <= 1'h0;
                        end else begin
                            state_reg <= ST_DATA;
                            cnt_reg <= 6'h00;
                            if (rd_reg) begin
                                mdio_o <= rd_data_i[15];
                                shift_reg <= {rd_data_i[14:0], 1'h0};
                            end
                        end
                    end
                    ST_DATA: begin
                        cnt_reg <= cnt_reg + 6'h01;
                        if (rd_reg) begin
                            mdio_o <= shift_reg[15];
                            shift_reg <= {shift_reg[14:0], 1'h0};
                        end else begin
                            shift_reg <= {shift_reg[14:0], bit_val};
                        end
                        if (cnt_reg == ppslc_pkg::DATA_LAST) begin
                            state_reg <= ST_PRE;
                            cnt_reg <= 6'h00;
                            mdio_oe_o <= 1'h0;
                            mdio_o <= 1'h0;
                            req_o.valid <= ~rd_reg;
                            req_o.data <= {shift_reg[14:0], bit_val};
                        end
                    end
                endcase
            end
        end
    end

endmodule

/* File: core/ppslc_phy_mgmt.sv */
// Operation
// - Enter power-down after 32 s idle.
// - Power-down gates only selected internal sections.
// - Indicator configuration register picks each event.
// - Events: link, activity, transmit, receive, speed, duplex.
// - Pins are inputs in reset, sampled at exit.
// - Software reset leaves pins driven, not resampled.
// - Management address comes from sampled pin levels.
// - Indicator asserted level inverts the sampled level.
// - Address zero tri-states the MAC interface.
// - Register map: basic, extended, reserved, vendor.
// - Isolate bit detaches MAC interface; strap default.
`timescale 1ns/1ps
module ppslc_phy_mgmt #(
    parameter logic [31:0] DPD_CYCLES = ppslc_pkg::DPD_CYCLES
) (
    // Clock and reset
    input logic clk_i,
    input logic reset_n_i,
    // Management pins
    input logic mdc_i,
    input logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    // Multi-function strap and indicator pins
    input logic strap_indicator_zero_i,
    output logic strap_indicator_zero_o,
    output logic strap_indicator_zero_oe_o,
    input logic strap_indicator_one_i,
    output logic strap_indicator_one_o,
    output logic strap_indicator_one_oe_o,
    // Link and MAC activity
    input logic link_up_i,
    input logic tx_enable_i,
    input logic rx_active_i,
    // Control and power outputs
    output ppslc_pkg::ppslc_ctrl_s ctrl_o,
    output logic [4:0] phy_addr_o,
    output logic rmii_oe_o,
    output logic deep_power_down_o,
    output logic [4:0] section_off_o
);

    // The idle timer compares against DPD_CYCLES - 1, so one cycle is too short to serve.
    if (DPD_CYCLES < 32'h0000_0002) begin : g_bad_dpd
        $error("DPD_CYCLES must be at least two");
    end

    ppslc_pkg::ppslc_req_s req;
    logic [15:0] rd_data_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] advert_reg;
    logic [15:0] np_tx_reg;
    logic [15:0] led_cfg_reg;
    logic [15:0] pd_sel_reg;
    logic [1:0] strap_meta_reg;
    logic [1:0] strap_sync_reg;
    logic [1:0] strap_val_reg;
    logic strap_done_reg;
    logic strap_oe_reg;
    logic [1:0] led_reg;
    logic [1:0] led_ev;
    logic tx_meta_reg;
    logic tx_sync_reg;
    logic [31:0] idle_cnt_reg;
    logic idle_cond;
    logic wr_ctrl;
    logic sw_rst;
    logic [4:0] pd_sel_w;

    ////////////////////////////////////////////////////////////////////////
    // Management frame engine.
    ppslc_mdio_slave u_mdio (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .mdc_i(mdc_i),
        .mdio_i(mdio_i),
        .mdio_o(mdio_o),
        .mdio_oe_o(mdio_oe_o),
        .phy_addr_i(phy_addr_o),
        .rd_data_i(rd_data_reg),
        .req_o(req)
    );

    // Decoded write strobes.
    assign wr_ctrl = req.valid && req.addr == ppslc_pkg::REG_CONTROL;
    assign sw_rst = wr_ctrl && req.data[ppslc_pkg::CTL_RESET];
    assign pd_sel_w = pd_sel_reg[ppslc_pkg::PD_SEL_LSB +: ppslc_pkg::PD_SEL_W];

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers run through reset so the strap is settled at release.
    always_ff @(posedge clk_i) begin
        strap_meta_reg <= {strap_indicator_one_i, strap_indicator_zero_i};
        strap_sync_reg <= strap_meta_reg;
        tx_meta_reg <= tx_enable_i;
        tx_sync_reg <= tx_meta_reg;
    end

    // Straps are caught once, on the first edge after hardware reset.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            strap_done_reg <= 1'h0;
            strap_val_reg <= 2'h0;
            phy_addr_o <= 5'h00;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'h1;
            strap_val_reg <= strap_sync_reg;
            phy_addr_o <= {3'h0, strap_sync_reg};
        end
    end

    // Pins stay inputs through hardware reset and the strap capture edge, and drive from the edge after that.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            strap_oe_reg <= 1'h0;
        end else begin
            strap_oe_reg <= strap_done_reg;
        end
    end

    assign strap_indicator_zero_oe_o = strap_oe_reg;
    assign strap_indicator_one_oe_o = strap_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // Event chosen for each indicator; unused codes keep it off.
    function automatic logic led_event(input logic [2:0] sel, input logic lnk, input logic tx,
                                       input logic rx, input logic spd, input logic dpx);
        case (ppslc_pkg::ppslc_led_src_e'(sel))
            ppslc_pkg::LED_LINK: led_event = lnk;
            ppslc_pkg::LED_ACT: led_event = tx | rx;
            ppslc_pkg::LED_TX: led_event = tx;
            ppslc_pkg::LED_RX: led_event = rx;
            ppslc_pkg::LED_SPEED: led_event = spd;
            ppslc_pkg::LED_DUPLEX: led_event = dpx;
            default: led_event = 1'h0;
        endcase
    endfunction

    for (genvar i = 0; i < 2; i++) begin : g_led
        localparam int SEL_LSB = (i == 0) ? ppslc_pkg::LED0_SEL_LSB : ppslc_pkg::LED1_SEL_LSB;
        // Selected event for this indicator.
        assign led_ev[i] = led_event(led_cfg_reg[SEL_LSB +: ppslc_pkg::LED_SEL_W], link_up_i, tx_sync_reg,
                                     rx_active_i, ctrl_reg[ppslc_pkg::CTL_SPEED],
                                     ctrl_reg[ppslc_pkg::CTL_DUPLEX]);
    end

    // An asserted event drives the opposite of the sampled strap level.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            led_reg <= 2'h0;
        end else begin
            led_reg <= led_ev ^ strap_val_reg;
        end
    end

    assign strap_indicator_zero_o = led_reg[0];
    assign strap_indicator_one_o = led_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // Control register; reset and restart bits are pulses and read zero.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctrl_reg <= ppslc_pkg::CTL_RESET_VAL;
        end else if (sw_rst) begin
            ctrl_reg <= ppslc_pkg::CTL_RESET_VAL;
            ctrl_reg[ppslc_pkg::CTL_ISOLATE] <= strap_val_reg[1];
        end else if (wr_ctrl) begin
            ctrl_reg <= req.data & ppslc_pkg::CTL_RW_MASK;
        end else if (!strap_done_reg) begin
            ctrl_reg[ppslc_pkg::CTL_ISOLATE] <= strap_sync_reg[1];
        end
    end

    // Decoded control outputs, with the two one-cycle action pulses.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctrl_o <= '0;
        end else begin
            ctrl_o.loopback <= ctrl_reg[ppslc_pkg::CTL_LOOPBACK];
            ctrl_o.speed_100 <= ctrl_reg[ppslc_pkg::CTL_SPEED];
            ctrl_o.autoneg_en <= ctrl_reg[ppslc_pkg::CTL_ANEN];
            ctrl_o.low_power <= ctrl_reg[ppslc_pkg::CTL_LOWPWR];
            ctrl_o.isolate <= ctrl_reg[ppslc_pkg::CTL_ISOLATE];
            ctrl_o.full_duplex <= ctrl_reg[ppslc_pkg::CTL_DUPLEX];
            ctrl_o.an_restart <= wr_ctrl && !sw_rst && req.data[ppslc_pkg::CTL_ANRST];
            ctrl_o.soft_reset <= sw_rst;
        end
    end

    // Other writable registers; a software reset restores their defaults.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || sw_rst) begin
            advert_reg <= ppslc_pkg::ADVERT_RESET;
            np_tx_reg <= ppslc_pkg::NP_TX_RESET;
            led_cfg_reg <= ppslc_pkg::LED_CFG_RESET;
            pd_sel_reg <= ppslc_pkg::PD_SEL_RESET;
        end else if (req.valid) begin
            case (req.addr)
                ppslc_pkg::REG_ADVERT: advert_reg <= req.data;
                ppslc_pkg::REG_NP_TX: np_tx_reg <= req.data;
                ppslc_pkg::REG_LED_CFG: led_cfg_reg <= req.data;
                ppslc_pkg::REG_PD_SEL: pd_sel_reg <= req.data;
                default: ;
            endcase
        end
    end

    // Read data follows the frame address; unmapped words read zero.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rd_data_reg <= 16'h0000;
        end else begin
            case (req.addr)
                ppslc_pkg::REG_CONTROL: rd_data_reg <= ctrl_reg;
                ppslc_pkg::REG_STATUS: rd_data_reg <= ppslc_pkg::STS_FIXED | {13'h0000, link_up_i, 2'h0};
                ppslc_pkg::REG_ID_HIGH: rd_data_reg <= ppslc_pkg::ID_HIGH_VAL;
                ppslc_pkg::REG_ID_LOW: rd_data_reg <= ppslc_pkg::ID_LOW_VAL;
                ppslc_pkg::REG_ADVERT: rd_data_reg <= advert_reg;
                ppslc_pkg::REG_NP_TX: rd_data_reg <= np_tx_reg;
                ppslc_pkg::REG_LED_CFG: rd_data_reg <= led_cfg_reg;
                ppslc_pkg::REG_PD_SEL: rd_data_reg <= pd_sel_reg;
                default: rd_data_reg <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // MAC interface drives only with a nonzero address and no isolation.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rmii_oe_o <= 1'h0;
        end else begin
            rmii_oe_o <= strap_done_reg && phy_addr_o != 5'h00 && !ctrl_reg[ppslc_pkg::CTL_ISOLATE];
        end
    end

    // Idle timer; any link or transmit activity restarts it and wakes up.
    assign idle_cond = !link_up_i && !tx_sync_reg;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !idle_cond) begin
            idle_cnt_reg <= 32'h0000_0000;
            deep_power_down_o <= 1'h0;
        end else if (idle_cnt_reg == DPD_CYCLES - 32'h0000_0001) begin
            deep_power_down_o <= 1'h1;
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
        end
    end

    // Only selected sections are switched off while powered down.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            section_off_o <= 5'h00;
        end else begin
            section_off_o <= deep_power_down_o ? pd_sel_w : 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the logic above.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence sw_rst_s;
        sw_rst;
    endsequence

    sequence an_rst_s;
        wr_ctrl && !sw_rst && req.data[ppslc_pkg::CTL_ANRST];
    endsequence

    dpd_entry_a: assert property ($rose(deep_power_down_o) |->
        $past(idle_cond) && idle_cnt_reg == DPD_CYCLES - 32'h0000_0001)
        else $error("power-down entered before the idle time");
    dpd_exit_a: assert property (!idle_cond |=> !deep_power_down_o && idle_cnt_reg == 32'h0000_0000)
        else $error("idle timer not restarted");
    section_gate_a: assert property (##1 section_off_o ==
        ($past(deep_power_down_o) ? $past(pd_sel_w) : 5'h00))
        else $error("section shutdown wrong");
    led_map_a: assert property (strap_done_reg |=>
        {strap_indicator_one_o, strap_indicator_zero_o} == ($past(led_ev) ^ strap_val_reg))
        else $error("indicator level wrong");
    strap_input_a: assert property ($past(!reset_n_i) |-> !strap_oe_reg ##1 !strap_oe_reg ##1 strap_oe_reg)
        else $error("strap pin direction wrong at reset exit");
    strap_hold_a: assert property (sw_rst_s |-> strap_oe_reg ##1 strap_oe_reg && $stable(strap_val_reg))
        else $error("software reset disturbed strap pins");
    addr_capture_a: assert property ($rose(strap_done_reg) |-> phy_addr_o == {3'h0, $past(strap_sync_reg)})
        else $error("address not taken from straps");
    rmii_off_a: assert property (strap_done_reg &&
        (phy_addr_o == 5'h00 || ctrl_reg[ppslc_pkg::CTL_ISOLATE]) |=> !rmii_oe_o)
        else $error("MAC interface driven while it must float");
    reserved_zero_a: assert property (req.addr >= ppslc_pkg::REG_RSVD_FIRST &&
        req.addr <= ppslc_pkg::REG_RSVD_LAST |=> rd_data_reg == 16'h0000)
        else $error("reserved register not zero");
    self_clear_a: assert property (an_rst_s |=> ctrl_o.an_restart ##1 !ctrl_o.an_restart)
        else $error("restart pulse wrong");
    ctrl_default_a: assert property (sw_rst_s |=> ctrl_reg[ppslc_pkg::CTL_SPEED] &&
        ctrl_reg[ppslc_pkg::CTL_ANEN] && ctrl_reg[ppslc_pkg::CTL_DUPLEX] &&
        !ctrl_reg[ppslc_pkg::CTL_LOOPBACK] && !ctrl_reg[ppslc_pkg::CTL_LOWPWR] && ctrl_o.soft_reset ##1
        !ctrl_o.soft_reset)
        else $error("control defaults wrong after software reset");

endmodule

/* File: core/ppslc_phy_mgmt_unused.sv */
`timescale 1ns/1ps

/* File: verif/ppslc_mac_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Station manager model: mdc stands low between frames and the line is released.
module ppslc_mac_model (
    // Clock
    input wire logic clk_i,
    // Management wire
    input wire logic mdio_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    // Idle state before the first frame.
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b0;
        mdio_oe_o = 1'b0;
    end

    // Sends one frame; read data is taken just before each rising mdc edge.
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] v;
        v = {32'hFFFFFFFF, 2'h1, op, pa, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(posedge clk_i);
            #1;
            mdc_o = 1'b0;
            mdio_oe_o = !(op == 2'h2 && i < 18);
            mdio_o = v[i];
            repeat (5) @(posedge clk_i);
            #1;
            if (op == 2'h2 && i < 16) begin
                rd[i] = mdio_i;
            end
            mdc_o = 1'b1;
            repeat (4) @(posedge clk_i);
        end
        @(posedge clk_i);
        #1;
        mdc_o = 1'b0;
        mdio_oe_o = 1'b0;
    endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk, reset_n, s0, s1, link_up, tx_en, rx_act;
    logic [4:0] pa;
    logic [15:0] rd;
    int errors, compares, cycles;
    wire logic mdc, mac_d, mac_oe, dut_d, dut_oe, o0, oe0, o1, oe1, rmii_oe, deep_power_down, mdio, pin0, pin1;
    wire logic [4:0] phy_addr, sect;
    ppslc_pkg::ppslc_ctrl_s ctrl;

    // Pull-up on the management line and strap resistors on the indicator pins.
    assign mdio = dut_oe ? dut_d : (mac_oe ? mac_d : 1'b1);
    assign pin0 = oe0 ? o0 : s0;
    assign pin1 = oe1 ? o1 : s1;

    ppslc_phy_mgmt #(.DPD_CYCLES(32'h14)) dut (.clk_i(clk), .reset_n_i(reset_n), .mdc_i(mdc),
        .mdio_i(mdio), .mdio_o(dut_d), .mdio_oe_o(dut_oe), .strap_indicator_zero_i(pin0),
        .strap_indicator_zero_o(o0), .strap_indicator_zero_oe_o(oe0), .strap_indicator_one_i(pin1),
        .strap_indicator_one_o(o1), .strap_indicator_one_oe_o(oe1), .link_up_i(link_up),
        .tx_enable_i(tx_en), .rx_active_i(rx_act), .ctrl_o(ctrl), .phy_addr_o(phy_addr),
        .rmii_oe_o(rmii_oe), .deep_power_down_o(deep_power_down), .section_off_o(sect));
    ppslc_mac_model mac (.clk_i(clk), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(mac_d), .mdio_oe_o(mac_oe));

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 125 MHz.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        mac.frame(ppslc_pkg::OP_WRITE, pa, ra, d, rd);
        tick(4);
    endtask

    task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
        mac.frame(ppslc_pkg::OP_READ, pa, ra, 16'h0000, rd);
        chk(rd, exp);
    endtask

    task automatic rst(input logic a, input logic b);
        reset_n = 1'b0;
        s0 = a;
        s1 = b;
        tick(12);
        chk(16'({oe0, oe1}), 16'h0000);
        reset_n = 1'b1;
        tick(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        {link_up, tx_en, rx_act, errors, compares, cycles} = '0;
        pa = 5'h01;
        rst(1'b1, 1'b0);
        chk(16'(phy_addr), 16'h0001);
        chk(16'({oe0, oe1, rmii_oe, o0}), 16'h000F);
        link_up = 1'b1;
        tick(3);
        chk(16'(o0), 16'h0000);
        $display("Test strap done");
        rdc(ppslc_pkg::REG_CONTROL, ppslc_pkg::CTL_RESET_VAL);
        rdc(ppslc_pkg::REG_STATUS, ppslc_pkg::STS_FIXED | 16'h0004);
        rdc(ppslc_pkg::REG_ID_HIGH, ppslc_pkg::ID_HIGH_VAL);
        rdc(ppslc_pkg::REG_ID_LOW, ppslc_pkg::ID_LOW_VAL);
        wr(ppslc_pkg::REG_RSVD_FIRST, 16'hFFFF);
        rdc(ppslc_pkg::REG_RSVD_FIRST, 16'h0000);
        wr(ppslc_pkg::REG_CONTROL, 16'h7FFF);
        rdc(ppslc_pkg::REG_CONTROL, ppslc_pkg::CTL_RW_MASK);
        chk(16'({ctrl, rmii_oe}), 16'h01F8);
        wr(ppslc_pkg::REG_CONTROL, 16'h8000);
        rdc(ppslc_pkg::REG_CONTROL, ppslc_pkg::CTL_RESET_VAL);
        chk(16'({oe0, oe1, phy_addr}), 16'h0061);
        $display("Test registers done");
        rx_act = 1'b1;
        for (int c = 0; c < 6; c++) begin
            wr(ppslc_pkg::REG_LED_CFG, 16'(c << 4));
            chk(16'(o1), 16'(6'h3B >> c) & 16'h0001);
        end
        $display("Test indicators done");
        wr(ppslc_pkg::REG_PD_SEL, 16'h0150);
        link_up = 1'b0;
        tick(16);
        tx_en = 1'b1;
        tick(3);
        tx_en = 1'b0;
        tick(18);
        chk(16'(deep_power_down), 16'h0000);
        tick(10);
        chk(16'({deep_power_down, sect}), 16'h0035);
        link_up = 1'b1;
        tick(4);
        chk(16'({deep_power_down, sect}), 16'h0000);
        mac.frame(ppslc_pkg::OP_READ, 5'h02, ppslc_pkg::REG_CONTROL, 16'h0000, rd);
        chk(rd, 16'hFFFF);
        $display("Test power-down done");
        rst(1'b0, 1'b0);
        chk(16'({phy_addr, rmii_oe}), 16'h0000);
        $display("Test address zero done");
        final_report();
    end
endmodule
